// file: hw/ltp_pkg.sv
// constants for the logic trigger programmer
package ltp_pkg;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned THR_W = 8;
    // threshold in 10 mV steps
    localparam int unsigned THR_STEP_MV = 10;
    localparam logic [THR_W-1:0] THR_DEFAULT = 8'h8C;
    localparam logic [THR_W-1:0] THR_MAX = 8'hFF;
    // time between threshold steps while held, in microseconds
    localparam int unsigned THR_RATE_US = 50;
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned THR_RATE_CYC = THR_RATE_US * CLK_MHZ;
    localparam int unsigned RATE_W = 12;
    // deflection index: 0 is most sensitive, DEFL_MAX is 5 V/div
    localparam int unsigned DEFL_W = 4;
    localparam logic [DEFL_W-1:0] DEFL_MAX = 4'hB;
    localparam logic [DEFL_W-1:0] DEFL_RESET = 4'h4;
    // term colour codes on the indicator
    typedef enum logic [1:0] {
        LTP_IND_OFF,
        LTP_IND_RED,
        LTP_IND_GREEN
    } ltp_ind_e;
endpackage : ltp_pkg

// file: hw/ltp_top.sv
// front-panel logic trigger combiner, four channels
// Summary of operation
// - negate press makes the last programmed channel's term active low, indicator green.
// - second negate press restores active high with red indicator.
// - program selector toggles into program-trigger mode, lit green.
// - selector light out means channel mode; channel buttons pick edited channel.
// - clear removes all terms; no trigger until a new term.
// - channel press in trigger mode adds active-high term, indicator red.
// - trigger uses thresholded input regardless of display enable.
// - unprogrammed channels do not contribute; empty function gives no trigger.
// - trigger monitor is high only while all active terms are true.
// - high term and low term trigger while first high and second low.
// - threshold defaults to 1.4 V and steps up while raise is held.
// - two logic-family presses restore 1.4 V and set the selected channel to 5 V/div.
// - upper deflection press steps the selected channel one position.
`timescale 1ns/1ps
`default_nettype none
module ltp_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // front-panel presses, one-cycle pulses from debounced logic
    input wire logic program_mode_select_i,
    input wire logic clear_i,
    input wire logic negate_i,
    input wire logic display_i,
    input wire logic defl_up_i,
    input wire logic logic_family_select_i,
    input wire logic [3:0] chan_btn_i,
    // level controls
    input wire logic level_raise_i,
    input wire logic threshold_edit_select_i,
    // comparator outputs, asynchronous
    input wire logic [3:0] chan_cmp_i,
    // status and trigger
    output logic program_mode_select_trig_led_o,
    output logic [7:0] term_ind_o,
    output logic [3:0] disp_en_o,
    output logic [1:0] sel_chan_o,
    output logic [15:0] defl_o,
    output logic [7:0] threshold_o,
    output logic trigger_o,
    output logic trigger_monitor_trace_o
);
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [3:0] cmp_m;
        logic [3:0] cmp_s;
        logic program_mode_select_trig;
        logic [3:0] term_on;
        logic [3:0] term_neg;
        logic [1:0] last_ch;
        logic [1:0] sel_ch;
        logic [3:0] disp;
        logic [15:0] defl;
        logic [7:0] thr;
        logic [11:0] rate_cnt;
        logic fam_press;
        logic trig;
        logic [7:0] ind;
    } ltp_state_s;

    ltp_state_s st;
    ltp_state_s next_st;
    logic rst_n;
    logic [3:0] term_true;
    logic [3:0] term_ok;

    assign rst_n = st.rst_sync[1];

    // the programmed terms evaluated on synchronised comparator levels
    for (genvar g = 0; g < 4; g++) begin : g_term
        assign term_true[g] = st.cmp_s[g] ^ st.term_neg[g];
        assign term_ok[g] = ~st.term_on[g] | term_true[g];
    end

    always_comb begin
        next_st = st;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        next_st.cmp_m = chan_cmp_i;
        next_st.cmp_s = st.cmp_m;
        if (program_mode_select_i) begin
            next_st.program_mode_select_trig = ~st.program_mode_select_trig;
        end
        for (int i = 0; i < 4; i++) begin
            if (chan_btn_i[i]) begin
                if (st.program_mode_select_trig) begin
                    next_st.term_on[i] = 1'b1;
                    next_st.term_neg[i] = 1'b0;
                    next_st.last_ch = 2'(i);
                end else begin
                    next_st.sel_ch = 2'(i);
                end
            end
        end
        if (st.program_mode_select_trig && negate_i && st.term_on[st.last_ch]) begin
            next_st.term_neg[st.last_ch] = ~st.term_neg[st.last_ch];
        end
        if (st.program_mode_select_trig && clear_i) begin
            next_st.term_on = 4'h0;
            next_st.term_neg = 4'h0;
        end
        if (!st.program_mode_select_trig && display_i) begin
            next_st.disp[st.sel_ch] = ~st.disp[st.sel_ch];
        end
        if (!st.program_mode_select_trig && defl_up_i && st.defl[st.sel_ch*4 +: 4] != ltp_pkg::DEFL_MAX) begin
            next_st.defl[st.sel_ch*4 +: 4] = st.defl[st.sel_ch*4 +: 4] + 4'h1;
        end
        // threshold steps at a slow rate so a held button ramps visibly
        if (level_raise_i && threshold_edit_select_i) begin
            if (st.rate_cnt == 12'(ltp_pkg::THR_RATE_CYC - 1)) begin
                next_st.rate_cnt = 12'h000;
                if (st.thr != ltp_pkg::THR_MAX) begin
                    next_st.thr = st.thr + 8'h01;
                end
            end else begin
                next_st.rate_cnt = st.rate_cnt + 12'h001;
            end
        end else begin
            next_st.rate_cnt = 12'h000;
        end
        if (logic_family_select_i) begin
            next_st.fam_press = ~st.fam_press;
            if (st.fam_press) begin
                next_st.thr = ltp_pkg::THR_DEFAULT;
                next_st.defl[st.sel_ch*4 +: 4] = ltp_pkg::DEFL_MAX;
            end
        end
        // empty function never triggers
        next_st.trig = (|st.term_on) & (&term_ok);
        for (int i = 0; i < 4; i++) begin
            if (!next_st.term_on[i]) begin
                next_st.ind[i*2 +: 2] = 2'(ltp_pkg::LTP_IND_OFF);
            end else if (next_st.term_neg[i]) begin
                next_st.ind[i*2 +: 2] = 2'(ltp_pkg::LTP_IND_GREEN);
            end else begin
                next_st.ind[i*2 +: 2] = 2'(ltp_pkg::LTP_IND_RED);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
            st.thr <= ltp_pkg::THR_DEFAULT;
            st.defl <= {4{ltp_pkg::DEFL_RESET}};
        end else if (!rst_n) begin
            st.rst_sync <= next_st.rst_sync;
        end else begin
            st <= next_st;
        end
    end

    assign program_mode_select_trig_led_o = st.program_mode_select_trig;
    assign term_ind_o = st.ind;
    assign disp_en_o = st.disp;
    assign sel_chan_o = st.sel_ch;
    assign defl_o = st.defl;
    assign threshold_o = st.thr;
    assign trigger_o = st.trig;
    assign trigger_monitor_trace_o = st.trig;

    a_empty_no_trig: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        ($past(st.term_on) == 4'h0)
        |-> !trigger_o
    ) else begin
        $error("trigger with empty function");
    end

    a_and_terms: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        trigger_o
        |-> $past(&term_ok)
    ) else begin
        $error("trigger while a term is false");
    end

    a_clear_all: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (st.program_mode_select_trig && clear_i)
        |=> (term_ind_o == 8'h00) ##1 !trigger_o
    ) else begin
        $error("clear left a term");
    end

    a_mode_toggle: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        program_mode_select_i
        |=> (program_mode_select_trig_led_o != $past(program_mode_select_trig_led_o))
    ) else begin
        $error("mode did not toggle");
    end

    a_chan_add: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (st.program_mode_select_trig && chan_btn_i[0] && !clear_i && !negate_i)
        |=> term_ind_o[1:0] == 2'h1
    ) else begin
        $error("ch0 not red");
    end

    a_negate_flip: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (st.program_mode_select_trig && negate_i && chan_btn_i == 4'h0 && !clear_i && st.term_on[st.last_ch])
        |=> st.term_neg[$past(st.last_ch)] != $past(st.term_neg[st.last_ch])
    ) else begin
        $error("negate failed");
    end

    a_mixed_terms: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        ($past(st.term_on) == 4'h6 && $past(st.term_neg) == 4'h4)
        |-> trigger_o == ($past(st.cmp_s[1]) && !$past(st.cmp_s[2]))
    ) else begin
        $error("mixed terms wrong");
    end

    a_single_term: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        ($past(st.term_on) == 4'h1 && $past(st.term_neg) == 4'h0)
        |-> trigger_o == $past(st.cmp_s[0])
    ) else begin
        $error("single term wrong");
    end

    a_family_reset: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (logic_family_select_i && st.fam_press)
        |=> threshold_o == ltp_pkg::THR_DEFAULT
    ) else begin
        $error("threshold not restored");
    end

    a_family_defl: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (logic_family_select_i && st.fam_press)
        |=> defl_o[$past(st.sel_ch)*4 +: 4] == ltp_pkg::DEFL_MAX
    ) else begin
        $error("deflection not forced");
    end

    a_fam_first: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (logic_family_select_i && !st.fam_press && !(level_raise_i && threshold_edit_select_i))
        |=> threshold_o == $past(threshold_o)
    ) else begin
        $error("first family press moved threshold");
    end

    a_thr_mono: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (level_raise_i && threshold_edit_select_i && !logic_family_select_i)
        |=> threshold_o >= $past(threshold_o)
    ) else begin
        $error("threshold fell");
    end

    a_thr_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!level_raise_i && !logic_family_select_i)
        |=> threshold_o == $past(threshold_o)
    ) else begin
        $error("threshold moved while idle");
    end

    a_defl_step: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!st.program_mode_select_trig && defl_up_i && !logic_family_select_i && chan_btn_i == 4'h0
            && st.defl[st.sel_ch*4 +: 4] != ltp_pkg::DEFL_MAX)
        |=> defl_o[$past(st.sel_ch)*4 +: 4] == $past(st.defl[st.sel_ch*4 +: 4]) + 4'h1
    ) else begin
        $error("deflection no step");
    end

    a_defl_sat: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!st.program_mode_select_trig && defl_up_i && !logic_family_select_i
            && st.defl[st.sel_ch*4 +: 4] == ltp_pkg::DEFL_MAX)
        |=> defl_o == $past(defl_o)
    ) else begin
        $error("deflection passed its limit");
    end

    a_chan_select: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!st.program_mode_select_trig && chan_btn_i[2] && !chan_btn_i[3])
        |=> sel_chan_o == 2'h2
    ) else begin
        $error("channel not selected");
    end

    a_disp_toggle: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (!st.program_mode_select_trig && display_i)
        |=> disp_en_o[$past(st.sel_ch)] != $past(disp_en_o[st.sel_ch])
    ) else begin
        $error("display did not toggle");
    end

    a_chan_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !st.program_mode_select_trig
        |=> term_ind_o == $past(term_ind_o)
    ) else begin
        $error("term changed in channel mode");
    end

    a_trig_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        (st.program_mode_select_trig && !logic_family_select_i)
        |=> (defl_o == $past(defl_o)) && (disp_en_o == $past(disp_en_o))
            && (sel_chan_o == $past(sel_chan_o))
    ) else begin
        $error("channel setting changed in trigger mode");
    end
endmodule // ltp_top
`default_nettype wire

// file: tb/ltp_tb_timebase.sv
// time-base model that counts delivered triggers
`timescale 1ns/1ps
`default_nettype none
module ltp_tb_timebase (
    // clock and trigger
    input wire logic clk_i,
    input wire logic trig_i,
    // sweeps started
    output logic [15:0] sweeps_o
);
    logic last = 1'b0;
    logic [15:0] count = 16'h0000;
    assign sweeps_o = count;
    // edge-started sweep, so a level that never drops starts only one
    always @(posedge clk_i) begin
        last <= trig_i;
        if (trig_i === 1'b1 && last === 1'b0) begin
            count <= count + 16'h0001;
        end
    end
endmodule // ltp_tb_timebase
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the logic trigger programmer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    // program_mode_select, clear, negate, display, defl_up, family
    logic [5:0] btn = 6'h00;
    logic [3:0] ch = 4'h0;
    logic [3:0] cmp = 4'h0;
    logic raise = 1'b0;
    logic thr_sel = 1'b0;
    logic led, trig, mon;
    logic [7:0] ind, thr;
    logic [3:0] disp;
    logic [1:0] sel;
    logic [15:0] defl, sweeps;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    initial forever #12.5 clk = ~clk;
    ltp_top i_dut (.core_clk_i(clk), .arst_n_i(arst_n), .program_mode_select_i(btn[0]), .clear_i(btn[1]),
        .negate_i(btn[2]), .display_i(btn[3]), .defl_up_i(btn[4]), .logic_family_select_i(btn[5]),
        .chan_btn_i(ch), .level_raise_i(raise), .threshold_edit_select_i(thr_sel), .chan_cmp_i(cmp),
        .program_mode_select_trig_led_o(led), .term_ind_o(ind), .disp_en_o(disp), .sel_chan_o(sel), .defl_o(defl),
        .threshold_o(thr), .trigger_o(trig), .trigger_monitor_trace_o(mon));
    ltp_tb_timebase i_tb (.clk_i(clk), .trig_i(trig), .sweeps_o(sweeps));
    // sample 1 ns past the edge so the design's updates have landed
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic push(input int k);
        @(posedge clk); btn[k] <= 1'b1;
        @(posedge clk); btn[k] <= 1'b0;
        wt(2);
    endtask
    task automatic pch(input int k);
        @(posedge clk); ch[k] <= 1'b1;
        @(posedge clk); ch[k] <= 1'b0;
        wt(2);
    endtask
    // comparator path is two sync flops plus the trigger register
    task automatic setc(input logic [3:0] v);
        @(posedge clk); cmp <= v;
        wt(5);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        wt(3);
        `CHK(thr, 8'h8C)
        `CHK(defl, 16'h4444)
        `CHK({led, ind, trig, mon}, 11'h000)
        $display("test reset done");
        push(0); `CHK(led, 1'b1)
        setc(4'h1); `CHK(trig, 1'b0)
        pch(0); `CHK(ind, 8'h01)
        wt(2); `CHK({trig, mon}, 2'b11)
        push(2); `CHK(ind, 8'h02)
        wt(2); `CHK(trig, 1'b0)
        push(2); `CHK(ind, 8'h01)
        push(1); `CHK(ind, 8'h00)
        wt(2); `CHK({trig, sweeps}, 17'h00002)
        $display("test single term done");
        pch(1); pch(2); push(2); `CHK(ind, 8'h24)
        setc(4'h2); `CHK(trig, 1'b1)
        setc(4'h6); `CHK(mon, 1'b0)
        setc(4'h0); `CHK(trig, 1'b0)
        setc(4'h2); `CHK(sweeps, 16'h0004)
        $display("test and terms done");
        push(0); `CHK(led, 1'b0)
        pch(2); `CHK({sel, ind}, 10'h224)
        push(4); `CHK(defl, 16'h4544)
        push(3); `CHK(disp, 4'h4)
        push(3); `CHK({disp, trig}, 5'h01)
        $display("test channel mode done");
        @(posedge clk); raise <= 1'b1; thr_sel <= 1'b1;
        wt(4100);
        @(posedge clk); raise <= 1'b0;
        wt(2); `CHK(thr, 8'h8E)
        push(5); `CHK(thr, 8'h8E)
        push(5); `CHK({thr, defl}, 24'h8C4B44)
        push(4); `CHK(defl, 16'h4B44)
        $display("test threshold done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
